// file: srx_bist_checker.sv
// expected byte generator for the receiver self-test loop
`timescale 1ns/1ns
`include "srx_params.svh"
module srx_bist_checker
  import srx_pkg::*;
#(
  parameter int LOOP_LEN = `SRX_BIST_LOOP_LEN
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic advance,
  // expectation for the current byte
  output logic [7:0] expByte,
  output logic loopLast
);
  logic [8:0] lfsr_reg;
  logic [8:0] lfsr_next;
  logic [8:0] idx_reg;
  logic [8:0] idx_next;

  always_comb
  begin
    lfsr_next = lfsr_reg;
    idx_next = idx_reg;
    if (start)
    begin
      // the loop marker itself was index zero
      idx_next = 9'h001;
      lfsr_next = `SRX_BIST_SEED;
    end
    else if (advance)
    begin
      if (idx_reg == 9'(LOOP_LEN - 1))
      begin
        idx_next = 9'h000;
        lfsr_next = `SRX_BIST_SEED;
      end
      else
      begin
        idx_next = idx_reg + 9'h001;
        lfsr_next = {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      lfsr_reg <= `SRX_BIST_SEED;
      idx_reg <= 9'h000;
    end
    else
    begin
      lfsr_reg <= lfsr_next;
      idx_reg <= idx_next;
    end
  end

  assign expByte = (idx_reg == 9'h000) ? `SRX_LOOP_START_BYTE
                                       : lfsr_reg[7:0];
  assign loopLast = (idx_reg == 9'(LOOP_LEN - 1));
endmodule

// file: srx_chk.sv
// port assertions for the serial receiver framing block
`timescale 1ns/1ns
`include "srx_params.svh"
module srx_chk
  import srx_pkg::*;
#(
  parameter int DBL_BYTES = `SRX_DOUBLE_BYTE_COUNT,
  parameter int LOOP_LEN = `SRX_BIST_LOOP_LEN
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // pins
  input wire logic serialInSecondN,
  input wire srx_mode_t modeSel,
  input wire logic selfTestEnableN,
  input wire logic statusStrapIn,
  input wire logic statusOut,
  input wire logic statusOutEn,
  // parallel side
  input wire logic [7:0] parallelOut,
  input wire logic specialCharFlag,
  input wire logic violationFlag,
  input wire logic readyN,
  input wire logic recoveredByteClock,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  strap_sel_a: assert property (
    $past(rstn, 2) |-> statusOutEn == !statusStrapIn)
    else $error("status pin drive disagrees with strap");
  status_follow_a: assert property (
    statusOutEn && $past(statusOutEn) |->
    statusOut == $past(serialInSecondN))
    else $error("status out does not follow monitor input");
  status_off_a: assert property (
    !statusOutEn |-> !statusOut)
    else $error("status out high while pin released");
  out_stable_a: assert property (
    !$rose(recoveredByteClock) |-> $stable(parallelOut) &&
    $stable(specialCharFlag) && $stable(violationFlag) && $stable(readyN))
    else $error("outputs changed away from byte clock rise");
  // a long look back keeps mode and self-test changes out of the window
  null_ready_a: assert property (
    $rose(recoveredByteClock) && modeSel == 2'h0 &&
    $past(modeSel, 24) == 2'h0 && selfTestEnableN &&
    $past(selfTestEnableN, 24) && specialCharFlag &&
    parallelOut == `SRX_NULL_BYTE |-> readyN)
    else $error("ready pulsed for null pad");
  data_ready_a: assert property (
    $rose(recoveredByteClock) && modeSel == 2'h0 &&
    $past(modeSel, 24) == 2'h0 && selfTestEnableN &&
    $past(selfTestEnableN, 24) && !specialCharFlag &&
    !violationFlag |-> !readyN)
    else $error("ready missing for data byte");
  rdata_idle_a: assert property (
    !$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read answer");
  unmapped_a: assert property (
    regRd && regAddr == 8'h14 |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_keep_a: assert property (
    regWr && regAddr == `SRX_ADDR_CTRL ##1
    regRd && regAddr == `SRX_ADDR_CTRL |=>
    regRdata == ($past(regWdata, 2) & 32'h1))
    else $error("control readback wrong");
endmodule
bind srx_framing_ctrl srx_chk #(.DBL_BYTES(DBL_BYTES), .LOOP_LEN(LOOP_LEN))
  chk (.core_clk, .rstn, .serialInSecondN, .modeSel, .selfTestEnableN,
  .statusStrapIn, .statusOut, .statusOutEn, .parallelOut, .specialCharFlag,
  .violationFlag, .readyN, .recoveredByteClock, .regAddr, .regWdata,
  .regWr, .regRd, .regRdata);

// file: srx_framing_ctrl.sv
// serial receiver framing, mode control, self-test and register port
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "srx_params.svh"
module srx_framing_ctrl
  import srx_pkg::*;
#(
  parameter int DBL_BYTES = `SRX_DOUBLE_BYTE_COUNT,
  parameter int LOOP_LEN = `SRX_BIST_LOOP_LEN
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // serial inputs
  input wire logic serialInFirst,
  input wire logic serialInSecondP,
  input wire logic serialInSecondN,
  input wire logic lineSelect,
  // control pins
  input wire logic reframeEnable,
  input wire srx_mode_t modeSel,
  input wire logic selfTestEnableN,
  input wire logic statusStrapIn,
  // status pin
  output logic statusOut,
  output logic statusOutEn,
  // parallel side
  output logic [7:0] parallelOut,
  output logic specialCharFlag,
  output logic violationFlag,
  output logic readyN,
  output logic recoveredByteClock,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic irq
);

  // ************************************************
  // strap and status translation
  // ************************************************
  logic strapDone_reg;
  logic strapDone_next;
  logic translator_reg;
  logic translator_next;
  logic statusOut_reg;
  logic statusOut_next;

  always_comb
  begin
    strapDone_next = 1'b1;
    translator_next = translator_reg;
    // strap is caught once, in the first cycle after reset release
    if (!strapDone_reg)
    begin
      translator_next = ~statusStrapIn;
    end
    statusOut_next = translator_reg & serialInSecondN;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      strapDone_reg <= 1'b0;
      translator_reg <= 1'b0;
      statusOut_reg <= 1'b0;
    end
    else
    begin
      strapDone_reg <= strapDone_next;
      translator_reg <= translator_next;
      statusOut_reg <= statusOut_next;
    end
  end

  assign statusOut = statusOut_reg;
  // a strapped pin is held at supply, so we must not fight it
  assign statusOutEn = translator_reg;

  // ************************************************
  // bit shifter and framer
  // ************************************************
  logic [9:0] shift_reg;
  logic [9:0] shift_next;
  logic [3:0] bitCnt_reg;
  logic [3:0] bitCnt_next;
  logic [3:0] commaAge_reg;
  logic [3:0] commaAge_next;
  logic [11:0] rfRun_reg;
  logic [11:0] rfRun_next;
  logic dbl_reg;
  logic dbl_next;
  logic testPrev_reg;
  logic [9:0] sym_reg;
  logic [9:0] sym_next;
  logic symStb_reg;
  logic symStb_next;
  logic bitEn;
  logic serialBit;
  logic isComma;
  logic realign;
  logic evRealign;
  logic testMode;

  assign testMode = (modeSel == `SRX_MODE_TEST);

  always_comb
  begin
    // test clock edge paces the shifter instead of the own bit clock
    bitEn = testMode ? (serialInSecondP & ~testPrev_reg) : 1'b1;
    serialBit = (lineSelect || testMode) ? serialInFirst : serialInSecondP;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    commaAge_next = commaAge_reg;
    sym_next = sym_reg;
    symStb_next = 1'b0;
    rfRun_next = rfRun_reg;
    dbl_next = dbl_reg;
    isComma = 1'b0;
    realign = 1'b0;
    evRealign = 1'b0;
    if (bitEn)
    begin
      shift_next = {shift_reg[8:0], serialBit};
      isComma = (shift_next == `SRX_COMMA_NEG) ||
                (shift_next == `SRX_COMMA_POS);
      commaAge_next = isComma ? 4'h0 :
        ((commaAge_reg == 4'hF) ? 4'hF : commaAge_reg + 4'h1);
      // double-byte mode needs two commas one symbol apart
      realign = reframeEnable && isComma &&
                (!dbl_reg || commaAge_reg == 4'h9);
      if (realign || bitCnt_reg == 4'(`SRX_SYM_BITS - 1))
      begin
        evRealign = realign && bitCnt_reg != 4'(`SRX_SYM_BITS - 1);
        bitCnt_next = 4'h0;
        sym_next = shift_next;
        symStb_next = 1'b1;
      end
      else
      begin
        bitCnt_next = bitCnt_reg + 4'h1;
      end
    end
    if (!reframeEnable)
    begin
      rfRun_next = 12'h000;
      dbl_next = 1'b0;
    end
    else if (symStb_next)
    begin
      if (rfRun_reg == 12'(DBL_BYTES - 1))
      begin
        dbl_next = 1'b1;
      end
      else
      begin
        rfRun_next = rfRun_reg + 12'h001;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      shift_reg <= 10'h000;
      bitCnt_reg <= 4'h0;
      commaAge_reg <= 4'hF;
      rfRun_reg <= 12'h000;
      dbl_reg <= 1'b0;
      testPrev_reg <= 1'b0;
      sym_reg <= 10'h000;
      symStb_reg <= 1'b0;
    end
    else
    begin
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      commaAge_reg <= commaAge_next;
      rfRun_reg <= rfRun_next;
      dbl_reg <= dbl_next;
      testPrev_reg <= serialInSecondP;
      sym_reg <= sym_next;
      symStb_reg <= symStb_next;
    end
  end

  // ************************************************
  // parallel outputs and self-test
  // ************************************************
  logic [7:0] decByte;
  logic decSpecial;
  logic decViol;
  logic [7:0] expByte;
  logic loopLast;
  logic bistStart;
  logic bistAdv;
  srx_bist_state_e bist_reg;
  srx_bist_state_e bist_next;
  logic [7:0] pout_reg;
  logic [7:0] pout_next;
  logic sc_reg;
  logic sc_next;
  logic viol_reg;
  logic viol_next;
  logic rdyN_reg;
  logic rdyN_next;
  logic bclk_reg;
  logic bclk_next;
  logic pend_reg;
  logic pend_next;
  logic outStb;
  logic rxEnable;
  logic evViol;
  logic evLoop;
  logic evBistErr;

  srx_symbol_decoder u_dec (
    .symbol(sym_reg),
    .dataByte(decByte),
    .special(decSpecial),
    .violation(decViol)
  );

  srx_bist_checker #(.LOOP_LEN(LOOP_LEN)) u_bist (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(bistStart),
    .advance(bistAdv),
    .expByte(expByte),
    .loopLast(loopLast)
  );

  always_comb
  begin
    pout_next = pout_reg;
    sc_next = sc_reg;
    viol_next = viol_reg;
    rdyN_next = rdyN_reg;
    bist_next = bist_reg;
    bistStart = 1'b0;
    bistAdv = 1'b0;
    evViol = 1'b0;
    evLoop = 1'b0;
    evBistErr = 1'b0;
    bclk_next = bclk_reg;
    pend_next = 1'b0;
    outStb = (symStb_reg || pend_reg) && rxEnable;
    if (bitEn && bitCnt_reg == 4'(`SRX_BYTE_CLK_HIGH))
    begin
      bclk_next = 1'b0;
    end
    // a realign can cut a symbol short while the byte clock is still high;
    // drop the clock one cycle so the update still rides a rising edge
    if (outStb && bclk_reg)
    begin
      outStb = 1'b0;
      pend_next = 1'b1;
      bclk_next = 1'b0;
    end
    // every output moves together with the byte clock rising edge
    if (outStb)
    begin
      bclk_next = 1'b1;
      if (modeSel == `SRX_MODE_RAW)
      begin
        for (int i = 0; i < 8; i++)
        begin
          pout_next[i] = sym_reg[8 - i];
        end
        sc_next = sym_reg[9];
        viol_next = sym_reg[0];
        rdyN_next = 1'b0;
        bist_next = SRX_BIST_IDLE;
      end
      else
      begin
        pout_next = decByte;
        sc_next = decSpecial;
        viol_next = decViol;
        evViol = decViol;
        // null pad bytes give no ready pulse, except in the self-test run state where readyN follows loopLast
        rdyN_next = decSpecial && decByte == `SRX_NULL_BYTE;
        if (selfTestEnableN)
        begin
          bist_next = SRX_BIST_IDLE;
        end
        else
        begin
          unique case (bist_reg)
            SRX_BIST_IDLE:
            begin
              bist_next = SRX_BIST_WAIT;
              rdyN_next = 1'b1;
            end
            SRX_BIST_WAIT:
            begin
              rdyN_next = 1'b1;
              if (!decSpecial && !decViol &&
                  decByte == `SRX_LOOP_START_BYTE)
              begin
                bist_next = SRX_BIST_RUN;
                bistStart = 1'b1;
                rdyN_next = 1'b0;
              end
            end
            SRX_BIST_RUN:
            begin
              bistAdv = 1'b1;
              viol_next = decViol || decByte != expByte;
              evBistErr = viol_next;
              evViol = 1'b0;
              rdyN_next = loopLast;
              evLoop = loopLast;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pout_reg <= 8'h00;
      sc_reg <= 1'b0;
      viol_reg <= 1'b0;
      rdyN_reg <= 1'b1;
      bclk_reg <= 1'b0;
      pend_reg <= 1'b0;
      bist_reg <= SRX_BIST_IDLE;
    end
    else
    begin
      pout_reg <= pout_next;
      sc_reg <= sc_next;
      viol_reg <= viol_next;
      rdyN_reg <= rdyN_next;
      bclk_reg <= bclk_next;
      pend_reg <= pend_next;
      bist_reg <= bist_next;
    end
  end

  assign parallelOut = pout_reg;
  assign specialCharFlag = sc_reg;
  assign violationFlag = viol_reg;
  assign readyN = rdyN_reg;
  assign recoveredByteClock = bclk_reg;

  // ************************************************
  // register port and interrupt
  // ************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [3:0] irqStat_reg;
  logic [3:0] irqStat_next;
  logic [3:0] irqMask_reg;
  logic [3:0] irqMask_next;
  logic [15:0] bistErr_reg;
  logic [15:0] bistErr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [3:0] events;

  assign rxEnable = ctrl_reg[`SRX_CTRL_RX_EN];

  always_comb
  begin
    events = 4'h0;
    events[`SRX_EV_VIOL] = evViol;
    events[`SRX_EV_REALIGN] = evRealign;
    events[`SRX_EV_LOOP] = evLoop;
    events[`SRX_EV_BIST_ERR] = evBistErr;
    ctrl_next = ctrl_reg;
    irqMask_next = irqMask_reg;
    irqStat_next = irqStat_reg;
    bistErr_next = bistErr_reg;
    rdata_next = 32'h0000_0000;
    if (regWr)
    begin
      if (regAddr == `SRX_ADDR_CTRL)
      begin
        ctrl_next = {31'h0000_0000, regWdata[`SRX_CTRL_RX_EN]};
      end
      if (regAddr == `SRX_ADDR_IRQ_MASK)
      begin
        irqMask_next = regWdata[3:0];
      end
      if (regAddr == `SRX_ADDR_IRQ_STAT)
      begin
        irqStat_next = irqStat_reg & ~regWdata[3:0];
      end
      if (regAddr == `SRX_ADDR_BIST_ERR)
      begin
        bistErr_next = 16'h0000;
      end
    end
    // a new event wins over a clear in the same cycle
    irqStat_next = irqStat_next | events;
    if (evBistErr && bistErr_next != 16'hFFFF)
    begin
      bistErr_next = bistErr_next + 16'h0001;
    end
    if (regRd)
    begin
      unique case (regAddr)
        `SRX_ADDR_CTRL: rdata_next = ctrl_reg;
        `SRX_ADDR_STATE: rdata_next = {25'h0, translator_reg, dbl_reg,
          bist_reg == SRX_BIST_RUN, bist_reg == SRX_BIST_WAIT,
          1'b0, modeSel};
        `SRX_ADDR_IRQ_STAT: rdata_next = {28'h0, irqStat_reg};
        `SRX_ADDR_IRQ_MASK: rdata_next = {28'h0, irqMask_reg};
        `SRX_ADDR_BIST_ERR: rdata_next = {16'h0, bistErr_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ctrl_reg <= `SRX_CTRL_RESET;
      irqStat_reg <= `SRX_IRQ_RESET;
      irqMask_reg <= `SRX_IRQ_RESET;
      bistErr_reg <= 16'h0000;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
      bistErr_reg <= bistErr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;
  assign irq = |(irqStat_reg & irqMask_reg);
endmodule

// file: srx_framing_ctrl_test.sv
// self-checking bench for the serial receiver framing block
`timescale 1ns/1ns
`include "srx_params.svh"
module srx_framing_ctrl_test;
  import srx_pkg::*;
  logic core_clk, rstn, lineSelect, reframeEnable;
  logic selfTestEnableN, statusStrapIn, statusIn;
  logic noise, hold, regWr, regRd;
  srx_mode_t modeSel;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic txBit, statusOut, statusOutEn, specialCharFlag, violationFlag;
  logic readyN, recoveredByteClock, irq, firstIn, secondP, secondN;
  logic [7:0] parallelOut;
  logic [10:0] recs[$];
  int err_total = 0, num_checks = 0, k;
  // ***********************************
  // harness
  // ***********************************
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  // unused line toggles while hold is low so it does not look like a held level
  always @(posedge core_clk) if (!hold) noise <= ~noise;
  assign firstIn = lineSelect ? txBit : noise;
  assign secondP = lineSelect ? noise : txBit;
  assign secondN = statusStrapIn ? ~secondP : statusIn;
  srx_link_tx tx (.core_clk(core_clk), .rstn(rstn), .serialOut(txBit));
  srx_framing_ctrl #(.DBL_BYTES(4), .LOOP_LEN(8)) dut (
    .core_clk(core_clk), .rstn(rstn), .serialInFirst(firstIn),
    .serialInSecondP(secondP), .serialInSecondN(secondN),
    .lineSelect(lineSelect), .reframeEnable(reframeEnable),
    .modeSel(modeSel), .selfTestEnableN(selfTestEnableN),
    .statusStrapIn(statusStrapIn), .statusOut(statusOut),
    .statusOutEn(statusOutEn), .parallelOut(parallelOut),
    .specialCharFlag(specialCharFlag), .violationFlag(violationFlag),
    .readyN(readyN), .recoveredByteClock(recoveredByteClock),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irq(irq));
  always @(posedge recoveredByteClock)
  begin
    @(negedge core_clk);
    recs.push_back({readyN, violationFlag, specialCharFlag, parallelOut});
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge core_clk);
    regWr <= 1'h0;
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge core_clk);
    regRd <= 1'h0;
    @(negedge core_clk);
    chk(regRdata & m, e);
    @(posedge core_clk);
  endtask
  task automatic bytes(input int n);
    repeat (n * 10) @(posedge core_clk);
  endtask
  task automatic doReset(input logic strap);
    rstn <= 1'h0;
    statusStrapIn <= strap;
    repeat (3) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (2) @(posedge core_clk);
  endtask
  // first record whose {special, byte} matches
  task automatic find(input logic [8:0] v);
    k = -1;
    foreach (recs[i])
      if (k < 0 && recs[i][8:0] === v)
        k = i;
    chk(k >= 0, 1'h1);
  endtask
  // ***********************************
  // scenarios
  // ***********************************
  initial
  begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    final_report();
  end
  initial
  begin
    lineSelect <= 1'h1;
    reframeEnable <= 1'h0;
    selfTestEnableN <= 1'h1;
    statusIn <= 1'h0;
    noise <= 1'h0;
    hold <= 1'h0;
    regWr <= 1'h0;
    regRd <= 1'h0;
    modeSel <= `SRX_MODE_DECODE;
    regAddr <= 8'h00;
    regWdata <= 32'h0;
    doReset(1'h0);
    rdm(`SRX_ADDR_IRQ_STAT, 32'hF, 32'h0);
    rdm(`SRX_ADDR_IRQ_MASK, 32'hF, 32'h0);
    rdm(`SRX_ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
    rdm(8'h14, 32'hFFFFFFFF, 32'h0);
    rdm(`SRX_ADDR_STATE, 32'h40, 32'h40);
    wr(`SRX_ADDR_CTRL, 32'hFFFFFFFF);
    rdm(`SRX_ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
    for (int v = 1; v >= 0; v--)
    begin
      statusIn <= v[0];
      repeat (3) @(posedge core_clk);
      chk({statusOutEn, statusOut}, {1'h1, v[0]});
    end
    reframeEnable <= 1'h1;
    bytes(30);
    rdm(`SRX_ADDR_STATE, 32'h20, 32'h20);
    wr(`SRX_ADDR_IRQ_STAT, 32'hF);
    recs.delete();
    tx.send(10'h2AA);
    tx.send(10'h155);
    tx.send(10'h000);
    bytes(8);
    chk(recs[0], 11'h5BC);
    find(9'h0B5);
    chk(recs[k], 11'h0B5);
    chk(recs[k + 1], 11'h04A);
    chk(recs[k + 2][9], 1'h1);
    rdm(`SRX_ADDR_IRQ_STAT, 32'h1, 32'h1);
    chk(irq, 1'h0);
    wr(`SRX_ADDR_IRQ_MASK, 32'h1);
    rdm(`SRX_ADDR_IRQ_MASK, 32'hF, 32'h1);
    chk(irq, 1'h1);
    wr(`SRX_ADDR_IRQ_STAT, 32'hF);
    rdm(`SRX_ADDR_IRQ_STAT, 32'hF, 32'h0);
    chk(irq, 1'h0);
    reframeEnable <= 1'h0;
    bytes(2);
    rdm(`SRX_ADDR_STATE, 32'h20, 32'h0);
    tx.slip();
    bytes(4);
    recs.delete();
    bytes(3);
    chk(recs.size() > 1, 1'h1);
    chk(recs[0][8:0] === 9'h1BC, 1'h0);
    rdm(`SRX_ADDR_IRQ_STAT, 32'h2, 32'h0);
    reframeEnable <= 1'h1;
    bytes(4);
    recs.delete();
    bytes(2);
    chk(recs[0], 11'h5BC);
    rdm(`SRX_ADDR_IRQ_STAT, 32'h2, 32'h2);
    wr(`SRX_ADDR_IRQ_STAT, 32'hF);
    modeSel <= `SRX_MODE_RAW;
    bytes(2);
    rdm(`SRX_ADDR_STATE, 32'h3, 32'h1);
    recs.delete();
    tx.send(10'h2AA);
    bytes(4);
    find(9'h1AA);
    chk(recs[k][9], 1'h0);
    // test clock held still: no bit clock, so no bytes
    hold <= 1'h1;
    modeSel <= `SRX_MODE_TEST;
    repeat (30) @(posedge core_clk);
    rdm(`SRX_ADDR_STATE, 32'h3, 32'h2);
    recs.delete();
    repeat (100) @(posedge core_clk);
    chk(recs.size(), 0);
    hold <= 1'h0;
    repeat (100) @(posedge core_clk);
    chk(recs.size() > 0, 1'h1);
    modeSel <= `SRX_MODE_DECODE;
    bytes(6);
    selfTestEnableN <= 1'h0;
    bytes(4);
    rdm(`SRX_ADDR_STATE, 32'h8, 32'h8);
    recs.delete();
    tx.send(10'h274);
    repeat (7) tx.send(10'h2AA);
    tx.send(10'h274);
    bytes(14);
    find(9'h000);
    chk(recs[k], 11'h000);
    for (int i = 1; i < 8; i++)
      chk(recs[k + i][10:9], (i == 7) ? 2'h3 : 2'h1);
    chk(recs[k + 8], 11'h000);
    rdm(`SRX_ADDR_STATE, 32'h10, 32'h10);
    rdm(`SRX_ADDR_IRQ_STAT, 32'hC, 32'hC);
    selfTestEnableN <= 1'h1;
    lineSelect <= 1'h0;
    doReset(1'h1);
    rdm(`SRX_ADDR_STATE, 32'h40, 32'h0);
    chk(statusOutEn, 1'h0);
    bytes(10);
    recs.delete();
    tx.send(10'h155);
    bytes(4);
    find(9'h04A);
    final_report();
  end
endmodule

// file: srx_link_tx.sv
// remote transmitter model sending ten-bit symbols one bit per cycle
`timescale 1ns/1ns
`include "srx_params.svh"
module srx_link_tx
(
  // clock and reset, shared with the receiver reference
  input wire logic core_clk,
  input wire logic rstn,
  // serial line
  output logic serialOut
);
  logic bitQ[$];
  logic dispPos;
  // bit a goes first
  task automatic send(input logic [9:0] sym);
    for (int i = 9; i >= 0; i--)
      bitQ.push_back(sym[i]);
  endtask
  // one surplus bit knocks the stream out of step
  task automatic slip();
    bitQ.push_back(1'h0);
  endtask
  // same clock as the receiver, so reference and byte rate match
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      bitQ.delete();
      dispPos <= 1'h0;
      serialOut <= 1'h0;
    end
    else
    begin
      // line is never idle: pad with alternating commas
      if (bitQ.size() == 0)
      begin
        send(dispPos ? `SRX_COMMA_POS : `SRX_COMMA_NEG);
        dispPos <= ~dispPos;
      end
      serialOut <= bitQ.pop_front();
    end
  end
endmodule

// file: srx_params.svh
// constants of the serial receiver framing and mode control block
`ifndef SRX_PARAMS_SVH
`define SRX_PARAMS_SVH
// register byte addresses
`define SRX_ADDR_CTRL 8'h00
`define SRX_ADDR_STATE 8'h04
`define SRX_ADDR_IRQ_STAT 8'h08
`define SRX_ADDR_IRQ_MASK 8'h0C
`define SRX_ADDR_BIST_ERR 8'h10
// fields
`define SRX_CTRL_RX_EN 0
`define SRX_CTRL_RESET 32'h0000_0001
`define SRX_IRQ_RESET 4'h0
`define SRX_EV_VIOL 0
`define SRX_EV_REALIGN 1
`define SRX_EV_LOOP 2
`define SRX_EV_BIST_ERR 3
// mode pin levels
`define SRX_MODE_DECODE 2'h0
`define SRX_MODE_RAW 2'h1
`define SRX_MODE_TEST 2'h2
// symbols and counts
`define SRX_COMMA_NEG 10'h0FA
`define SRX_COMMA_POS 10'h305
`define SRX_NULL_BYTE 8'hBC
`define SRX_LOOP_START_BYTE 8'h00
`define SRX_SYM_BITS 10
`define SRX_DOUBLE_BYTE_COUNT 2048
`define SRX_BIST_LOOP_LEN 511
`define SRX_BIST_SEED 9'h1FF
`define SRX_BYTE_CLK_HIGH 5
`endif

// file: srx_pkg.sv
// types shared by the serial receiver files
package srx_pkg;
  typedef logic [1:0] srx_mode_t;
  typedef enum logic [1:0] {SRX_BIST_IDLE, SRX_BIST_WAIT, SRX_BIST_RUN}
    srx_bist_state_e;
endpackage

// file: srx_symbol_decoder.sv
// ten-bit to byte decoder for one received symbol
`timescale 1ns/1ns
module srx_symbol_decoder
  import srx_pkg::*;
(
  // symbol, bit a in the msb
  input wire logic [9:0] symbol,
  // decoded result
  output logic [7:0] dataByte,
  output logic special,
  output logic violation
);
  localparam logic [5:0] TBL6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] TBL4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  function automatic logic [2:0] ones6(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++)
    begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  logic [5:0] s6;
  logic [3:0] s4;
  logic ok6;
  logic ok4;
  logic [4:0] x5;
  logic [2:0] y3;

  always_comb
  begin
    s6 = symbol[9:4];
    s4 = symbol[3:0];
    ok6 = 1'b0;
    ok4 = 1'b0;
    x5 = 5'h00;
    y3 = 3'h0;
    special = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      if (s6 == TBL6[i] || (s6 == ~TBL6[i] &&
          (ones6(TBL6[i]) != 3'h3 || i == 7)))
      begin
        x5 = 5'(i);
        ok6 = 1'b1;
      end
    end
    // comma-class control symbols; positive disparity flips the tail
    if (s6 == 6'h0F || s6 == 6'h30)
    begin
      x5 = 5'h1C;
      ok6 = 1'b1;
      special = 1'b1;
      if (s6 == 6'h30)
      begin
        s4 = ~s4;
      end
    end
    for (int j = 0; j < 8; j++)
    begin
      if (s4 == TBL4[j] ||
          (s4 == ~TBL4[j] && (j == 0 || j == 3 || j == 4 || j == 7)))
      begin
        y3 = 3'(j);
        ok4 = 1'b1;
      end
    end
    if (s4 == 4'h7 || s4 == 4'h8)
    begin
      y3 = 3'h7;
      ok4 = 1'b1;
    end
    dataByte = {y3, x5};
    violation = ~(ok6 & ok4);
  end
endmodule
